// ===== include/port7_mux_pkg.sv
// constants and types shared by the port 7 pin function selector
package port7_mux_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [7:0] OFS_IOCR0    = 8'h00;
    localparam logic [7:0] OFS_IOCR1    = 8'h04;
    localparam logic [7:0] OFS_IOCR2    = 8'h08;
    localparam logic [7:0] OFS_IOCR3    = 8'h0C;
    localparam logic [7:0] OFS_PORT_OUT = 8'h10;
    localparam logic [7:0] OFS_PORT_IN  = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;

    // selector field inside each pin_io_control_reg
    localparam int unsigned SEL_LSB = 4;
    localparam int unsigned SEL_W   = 4;
    localparam int unsigned SEL_EN  = 3;
    localparam logic [3:0]  SEL_RST = 4'h0;
    localparam logic [3:0]  OUT_RST = 4'h0;

    // alternate output indices in the selector low bits
    localparam logic [1:0] ALT0 = 2'h0;
    localparam logic [1:0] ALT1 = 2'h1;
    localparam logic [1:0] ALT2 = 2'h2;
    localparam logic [1:0] ALT3 = 2'h3;

    // status register bit positions
    localparam int unsigned ST_DBG_ACTIVE = 0;
    localparam int unsigned ST_TEST_MODE  = 1;
    localparam int unsigned ST_TDO_PD     = 2;
    localparam int unsigned ST_TDI_PU     = 3;
    localparam int unsigned ST_DBG_RST    = 4;

    // debug access port positions chosen at start-up
    localparam logic [1:0] DBG_PORT_POS0 = 2'h0;
    localparam logic [1:0] DBG_PORT_POS2 = 2'h2;

    // start-up sequence after power-on reset release
    typedef enum logic [3:0] {
        SU_SYNC0  = 4'b0001,
        SU_SYNC1  = 4'b0010,
        SU_SAMPLE = 4'b0100,
        SU_RUN    = 4'b1000
    } startup_t;

endpackage : port7_mux_pkg

// ===== rtl/port7_pin_mux.sv
// port 7 bits 0 to 3 pin function selector with wishbone registers
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps

module port7_pin_mux
    import port7_mux_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              core_clk,             // system clock
    input  wire logic              rst_n,                // power-on reset
    // wishbone slave
    input  wire logic              wb_cyc_i,             // bus cycle
    input  wire logic              wb_stb_i,             // strobe
    input  wire logic              wb_we_i,              // write
    input  wire logic [ADDR_W-1:0] wb_adr_i,             // byte address
    input  wire logic [31:0]       wb_dat_i,             // write data
    input  wire logic [3:0]        wb_sel_i,             // byte lanes
    output logic      [31:0]       wb_dat_o,             // read data
    output logic                   wb_ack_o,             // acknowledge
    // pads of port 7 bits 0 to 3
    input  wire logic [3:0]        pin_in,               // pad levels
    output logic      [3:0]        pin_out,              // pad drive
    output logic      [3:0]        pin_oe,               // pad enable
    // start-up and debug pins
    input  wire logic              debug_reset_in,       // test reset pin
    input  wire logic              factory_test_strap,   // strap pin
    input  wire logic [1:0]        dbg_port_sel,         // start-up port
    input  wire logic              jtag_pos_c_sel,       // start-up jtag
    input  wire logic              tdo_out,              // debug data
    input  wire logic              tdo_oe,               // debug drives
    // peripheral outputs to be routed
    input  wire logic              timer3_toggle_out,    // timer T3
    input  wire logic              timer6_toggle_out,    // timer T6
    input  wire logic              analog_mux_ctl0,      // mux bit 0
    input  wire logic              analog_mux_ctl1,      // mux bit 1
    input  wire logic              serial_ch1_data_out,  // serial 1
    input  wire logic              serial_ch0_data_out,  // serial 0
    input  wire logic              prog_clock_out,       // clock out
    // peripheral inputs from the pins
    output logic                   capcomp_position_in0, // bit 2
    output logic                   capcomp_position_in1, // bit 3
    output logic                   capcomp_trap_in,      // bit 1
    output logic                   debug_break_in,       // bit 1
    output logic                   service_req_trigger,  // bit 0
    output logic                   serial_ch1_data_in,   // bit 3
    output logic                   tdi_in,               // bit 2
    output logic                   tms_in,               // bit 3
    // debug and test state
    output logic                   debug_active,         // latched
    output logic                   debug_sys_reset,      // hold debug
    output logic                   test_mode_en,         // strap low
    output logic                   tdo_pulldown_en,      // pad pull
    output logic                   tdi_pullup_en         // pad pull
);
    // offsets need five address bits; buses wider than eight bits alias
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 32");
    end

    ////////////////////////////////////////////////////////////////////
    // helpers

    // output enable bit of a selector field
    function automatic logic sel_en(input logic [SEL_W-1:0] f);
        return f[SEL_EN];
    endfunction : sel_en

    // alternate index; bit 2 is stored but does not steer
    function automatic logic [1:0] sel_idx(input logic [SEL_W-1:0] f);
        return f[1:0];
    endfunction : sel_idx

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic       trst_s1;
    logic       trst_s2;
    logic       strap_s1;
    logic       strap_s2;
    logic [3:0] next_pin_s1;
    logic       next_trst_s1;
    logic       next_strap_s1;

    // first stage is read by the second stage only
    always_comb begin
        next_pin_s1   = pin_in;
        next_trst_s1  = debug_reset_in;
        next_strap_s1 = factory_test_strap;
    end

    // strap resets high so no false test mode at start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1   <= 4'h0;
            pin_s2   <= 4'h0;
            trst_s1  <= 1'b0;
            trst_s2  <= 1'b0;
            strap_s1 <= 1'b1;
            strap_s2 <= 1'b1;
        end else begin
            pin_s1   <= next_pin_s1;
            pin_s2   <= pin_s1;
            trst_s1  <= next_trst_s1;
            trst_s2  <= trst_s1;
            strap_s1 <= next_strap_s1;
            strap_s2 <= strap_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // start-up capture after power-on reset

    startup_t state;
    startup_t next_state;
    logic     next_debug_active;
    logic     next_tdo_pd;
    logic     next_tdi_pu;
    logic     next_dbg_rst;
    logic     next_test_mode;

    // wait two edges so the synchronised level is the real pin
    always_comb begin
        next_state        = state;
        next_debug_active = debug_active;
        next_tdo_pd       = tdo_pulldown_en;
        next_tdi_pu       = tdi_pullup_en;
        unique case (state)
            SU_SYNC0: next_state = SU_SYNC1;
            SU_SYNC1: next_state = SU_SAMPLE;
            SU_SAMPLE: begin
                next_state        = SU_RUN;
                next_debug_active = trst_s2;
                next_tdo_pd       = (dbg_port_sel == DBG_PORT_POS0) ||
                                    (dbg_port_sel == DBG_PORT_POS2);
                next_tdi_pu       = jtag_pos_c_sel;
            end
            SU_RUN:   next_state = SU_RUN;
        endcase
        // the probe pulls the reset pin low to clear the debug system
        next_dbg_rst   = !next_debug_active || !trst_s2;
        // low strap opens factory test modes
        next_test_mode = !strap_s2;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state           <= SU_SYNC0;
            debug_active    <= 1'b0;
            tdo_pulldown_en <= 1'b0;
            tdi_pullup_en   <= 1'b0;
            debug_sys_reset <= 1'b1;
            test_mode_en    <= 1'b0;
        end else begin
            state           <= next_state;
            debug_active    <= next_debug_active;
            tdo_pulldown_en <= next_tdo_pd;
            tdi_pullup_en   <= next_tdi_pu;
            debug_sys_reset <= next_dbg_rst;
            test_mode_en    <= next_test_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone slave and registers

    logic [SEL_W-1:0] iocr [4];
    logic [SEL_W-1:0] next_iocr [4];
    logic [3:0]       port_val;
    logic [3:0]       next_port_val;
    logic [31:0]      next_dat;
    logic             next_ack;
    logic             req;
    logic             wr;
    logic [7:0]       adr;

    // answer one edge after the request; write lands on the next edge, while ack is high
    always_comb begin
        adr           = 8'(wb_adr_i);
        req           = wb_cyc_i && wb_stb_i;
        next_ack      = req && !wb_ack_o;
        wr            = req && wb_ack_o && wb_we_i && wb_sel_i[0];
        next_port_val = port_val;
        next_dat      = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            next_iocr[i] = iocr[i];
            if (wr && adr == OFS_IOCR0 + 8'(4 * i)) begin
                next_iocr[i] = wb_dat_i[SEL_LSB +: SEL_W];
            end
            if (adr == OFS_IOCR0 + 8'(4 * i)) begin
                next_dat[SEL_LSB +: SEL_W] = iocr[i];
            end
        end
        if (wr && adr == OFS_PORT_OUT) begin
            next_port_val = wb_dat_i[3:0];
        end
        // unmapped offsets still ack and read as zero
        unique case (adr)
            OFS_PORT_OUT: next_dat[3:0] = port_val;
            OFS_PORT_IN:  next_dat[3:0] = pin_s2;
            OFS_STATUS: begin
                next_dat[ST_DBG_ACTIVE] = debug_active;
                next_dat[ST_TEST_MODE]  = test_mode_en;
                next_dat[ST_TDO_PD]     = tdo_pulldown_en;
                next_dat[ST_TDI_PU]     = tdi_pullup_en;
                next_dat[ST_DBG_RST]    = debug_sys_reset;
            end
            default: ;
        endcase
        if (!next_ack) begin
            next_dat = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                iocr[i] <= SEL_RST;
            end
            port_val <= OUT_RST;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            iocr     <= next_iocr;
            port_val <= next_port_val;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output selection per pin

    logic [3:0] next_pin_out;
    logic [3:0] next_pin_oe;

    // undefined alternates leave the pin as input only
    always_comb begin
        next_pin_out = 4'h0;
        next_pin_oe  = 4'h0;
        for (int i = 0; i < 4; i++) begin
            next_pin_oe[i] = sel_en(iocr[i]);
        end
        // bit 0
        unique case (sel_idx(iocr[0]))
            ALT0: next_pin_out[0] = port_val[0];
            ALT1: next_pin_out[0] = timer3_toggle_out;
            ALT2: next_pin_out[0] = timer6_toggle_out;
            ALT3: next_pin_oe[0]  = 1'b0;
        endcase
        // bit 1
        unique case (sel_idx(iocr[1]))
            ALT0: next_pin_out[1] = port_val[1];
            ALT1: next_pin_out[1] = prog_clock_out;
            default: next_pin_oe[1] = 1'b0;
        endcase
        // bit 2
        unique case (sel_idx(iocr[2]))
            ALT0: next_pin_out[2] = port_val[2];
            ALT1: next_pin_out[2] = analog_mux_ctl0;
            default: next_pin_oe[2] = 1'b0;
        endcase
        // bit 3
        unique case (sel_idx(iocr[3]))
            ALT0: next_pin_out[3] = port_val[3];
            ALT1: next_pin_out[3] = analog_mux_ctl1;
            ALT2: next_pin_out[3] = serial_ch1_data_out;
            ALT3: next_pin_out[3] = serial_ch0_data_out;
        endcase
        // debug owns test data out regardless of the selector
        if (debug_active && tdo_oe) begin
            next_pin_oe[0]  = 1'b1;
            next_pin_out[0] = tdo_out;
        end
        // clear drive value when disabled so the pad sees no glitch
        next_pin_out = next_pin_out & next_pin_oe;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 4'h0;
            pin_oe  <= 4'h0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // input routing to peripherals

    logic [7:0] in_route;
    logic [7:0] next_in_route;

    // pin levels reach every input function whatever drives the pad
    always_comb begin
        next_in_route[0] = pin_s2[2];
        next_in_route[1] = pin_s2[3];
        next_in_route[2] = pin_s2[1];
        next_in_route[3] = pin_s2[1];
        next_in_route[4] = pin_s2[0];
        next_in_route[5] = pin_s2[3];
        next_in_route[6] = pin_s2[2];
        next_in_route[7] = pin_s2[3];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_route <= 8'h00;
        end else begin
            in_route <= next_in_route;
        end
    end

    // each routed input comes straight from its flip-flop
    assign capcomp_position_in0 = in_route[0];
    assign capcomp_position_in1 = in_route[1];
    assign capcomp_trap_in      = in_route[2];
    assign debug_break_in       = in_route[3];
    assign service_req_trigger  = in_route[4];
    assign serial_ch1_data_in   = in_route[5];
    assign tdi_in               = in_route[6];
    assign tms_in               = in_route[7];
endmodule : port7_pin_mux

// ===== test/pad_model.sv
// pad and pull model standing on the far side of port 7 bits 0 to 3
`timescale 1ns/100ps
module pad_model (
    input  wire logic       core_clk, // clock
    input  wire logic [3:0] pin_out,  // design drive
    input  wire logic [3:0] pin_oe,   // design enable
    input  wire logic [3:0] ext_val,  // board drive
    input  wire logic [3:0] ext_en,   // board enable
    input  wire logic       pd0,      // pull-down on bit 0
    input  wire logic       pu2,      // pull-up on bit 2
    output logic      [3:0] pin_in    // pad levels
);
    logic [3:0] last = 4'h0; // known start, floating pads never unknown
    ////////////////////////////////////////////////////////////////////
    // last level, so a floating pad never shows a stale value
    always @(posedge core_clk) begin
        last <= pin_in;
    end
    // wire level, design drive before board drive, pulls only when nobody drives
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (i == 0 && pd0)
                pin_in[i] = 1'b0;
            else if (i == 2 && pu2)
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~last[i];
        end
    end
endmodule : pad_model

// ===== test/port7_pin_mux_props.sv
// assertions on the ports of the port 7 pin selector
`timescale 1ns/100ps
module port7_pin_mux_chk (
    input wire logic        core_clk,             // clock
    input wire logic        rst_n,                // reset
    input wire logic        wb_cyc_i,             // cycle
    input wire logic        wb_stb_i,             // strobe
    input wire logic        wb_ack_o,             // ack
    input wire logic [31:0] wb_dat_o,             // read data
    input wire logic [3:0]  pin_in,               // pads in
    input wire logic [3:0]  pin_out,              // pads out
    input wire logic [3:0]  pin_oe,               // pads enable
    input wire logic        tdo_out,              // debug data
    input wire logic        tdo_oe,               // debug drives
    input wire logic        capcomp_trap_in,      // bit 1
    input wire logic        debug_break_in,       // bit 1
    input wire logic        service_req_trigger,  // bit 0
    input wire logic        capcomp_position_in0, // bit 2
    input wire logic        debug_active,         // latched
    input wire logic        debug_sys_reset,      // debug hold
    input wire logic        tdo_pulldown_en       // pad pull
);
    logic [2:0] age;
    logic [2:0] next_age;
    ////////////////////////////////////////////////////////////////////
    // edges since release, masks the synchroniser start-up
    always_comb next_age = (age == 3'h7) ? age : age + 3'h1;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) age <= 3'h0;
        else age <= next_age;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_pulse; endproperty
    a_ack: assert property (p_ack)
        else $error("ack not a pulse one cycle after request");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle)
        else $error("read data outside ack");
    property p_trap;
        age >= 3'h4 |-> capcomp_trap_in == $past(pin_in[1], 3) &&
                        debug_break_in == capcomp_trap_in;
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap or break input not following bit 1");
    property p_esr;
        age >= 3'h4 |-> service_req_trigger == $past(pin_in[0], 3);
    endproperty
    a_esr: assert property (p_esr)
        else $error("service trigger not following bit 0");
    property p_pos0;
        age >= 3'h4 |-> capcomp_position_in0 == $past(pin_in[2], 3);
    endproperty
    a_pos0: assert property (p_pos0)
        else $error("position input 0 not following bit 2");
    property p_ovr;
        debug_active && tdo_oe |=> pin_oe[0] && pin_out[0] == $past(tdo_out);
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("debug data out not on bit 0");
    property p_quiet; (pin_out & ~pin_oe) == 4'h0; endproperty
    a_quiet: assert property (p_quiet)
        else $error("pad driven level while not enabled");
    property p_hold;
        age >= 3'h4 |-> $stable(debug_active) && $stable(tdo_pulldown_en);
    endproperty
    a_hold: assert property (p_hold)
        else $error("start-up latch changed after start-up");
    property p_dbgrst; !debug_active |-> debug_sys_reset; endproperty
    a_dbgrst: assert property (p_dbgrst)
        else $error("inactive debug system not held in reset");
endmodule : port7_pin_mux_chk
bind port7_pin_mux port7_pin_mux_chk u_chk (.core_clk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_dat_o, .pin_in, .pin_out, .pin_oe, .tdo_out,
    .tdo_oe, .capcomp_trap_in, .debug_break_in, .service_req_trigger,
    .capcomp_position_in0, .debug_active, .debug_sys_reset,
    .tdo_pulldown_en);

// ===== test/tb_top.sv
// self-checking bench for the port 7 pin function selector
`timescale 1ns/100ps
module tb_top;
    import port7_mux_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, dbg_rst = 1'b1, jtc = 1'b1, tdo_out = 1'b0;
    logic        tdo_oe = 1'b0, ack, esr, trap, brk, pos0, pos1, s1in;
    logic        tdi, tms, act, sysrst, tmode, pd, pu, strap = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q, rs = 32'hF2DA9B65;
    logic [3:0]  sel = 4'h0, ext_val = 4'h0, ext_en = 4'h0, pin_in;
    logic [3:0]  pin_out, pin_oe, pv;
    logic [1:0]  dport = DBG_PORT_POS2, e;
    logic [6:0]  per = 7'h00; // prog, s0, s1, m1, m0, t6, t3
    int          bad_count = 0, n_compared = 0;
    always #10 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////
    port7_pin_mux u_port7_pin_mux (.core_clk(core_clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .debug_reset_in(dbg_rst), .factory_test_strap(strap),
        .dbg_port_sel(dport), .jtag_pos_c_sel(jtc), .tdo_out(tdo_out),
        .tdo_oe(tdo_oe), .timer3_toggle_out(per[0]),
        .timer6_toggle_out(per[1]), .analog_mux_ctl0(per[2]),
        .analog_mux_ctl1(per[3]), .serial_ch1_data_out(per[4]),
        .serial_ch0_data_out(per[5]), .prog_clock_out(per[6]),
        .capcomp_position_in0(pos0), .capcomp_position_in1(pos1),
        .capcomp_trap_in(trap), .debug_break_in(brk),
        .service_req_trigger(esr), .serial_ch1_data_in(s1in),
        .tdi_in(tdi), .tms_in(tms), .debug_active(act),
        .debug_sys_reset(sysrst), .test_mode_en(tmode),
        .tdo_pulldown_en(pd), .tdi_pullup_en(pu));
    pad_model u_pad_model (.core_clk(core_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pd0(pd),
        .pu2(pu), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : next_rand
    // expected {enable, level} of a pad for a pin and alternate
    function automatic logic [1:0] exp_pin(input int p, input int a);
        case ({p[1:0], a[1:0]})
            4'h0, 4'h4, 4'h8, 4'hC: return {1'b1, pv[p]};
            4'h1: return {1'b1, per[0]};
            4'h2: return {1'b1, per[1]};
            4'h5: return {1'b1, per[6]};
            4'h9: return {1'b1, per[2]};
            4'hD: return {1'b1, per[3]};
            4'hE: return {1'b1, per[4]};
            4'hF: return {1'b1, per[5]};
            default: return 2'b00;
        endcase
    endfunction : exp_pin
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %0t word %h expected %h", $time, g, x);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic g, input logic x);
        n_compared++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %0t bit %b expected %b", $time, g, x);
        end
    endtask : cmp_bit
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
        @(posedge core_clk);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk);
        end
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            print_verdict();
        end
    endtask : wb
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle
    task automatic do_reset(input logic r, input logic [1:0] d, input logic j);
        @(posedge core_clk);
        rst_n <= 1'b0; dbg_rst <= r; dport <= d; jtc <= j;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b1, DBG_PORT_POS2, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0, 4'hF);
            cmp_word(q, 32'h0);
        end
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        cmp_word(q, 32'h0000000D);
        settle(6);
        cmp_bit(esr, 1'b0);
        cmp_bit(tdi, 1'b1);
        cmp_bit(sysrst, 1'b0);
        @(posedge core_clk);
        dbg_rst <= 1'b0;
        strap <= 1'b0;
        settle(5);
        cmp_bit(sysrst, 1'b1);
        cmp_bit(act, 1'b1);
        cmp_bit(tmode, 1'b1);
        @(posedge core_clk);
        strap <= 1'b1;
        settle(3);
        cmp_bit(tmode, 1'b0);
        $display("test start-up done");
        for (int p = 0; p < 4; p++) begin
            for (int a = 0; a < 4; a++) begin
                rs = next_rand(rs);
                @(posedge core_clk);
                per <= rs[6:0];
                pv = rs[11:8];
                wb(1'b1, OFS_PORT_OUT, {28'h0, pv}, 4'h1);
                wb(1'b1, 8'(p * 4), {24'h0, 1'b1, rs[12], a[1:0], 4'h0}, 4'h1);
                settle(1);
                e = exp_pin(p, a);
                cmp_bit(pin_oe[p], e[1]);
                cmp_bit(pin_out[p], e[0]);
            end
            wb(1'b1, 8'(p * 4), 32'h70, 4'h1);
            settle(1);
            cmp_bit(pin_oe[p], 1'b0);
        end
        wb(1'b1, OFS_IOCR3, 32'hB0, 4'h0);
        wb(1'b0, OFS_IOCR3, 32'h0, 4'hF);
        cmp_word(q, 32'h70);
        wb(1'b1, 8'h1C, 32'hFF, 4'hF);
        wb(1'b0, 8'h1C, 32'h0, 4'hF);
        cmp_word(q, 32'h0);
        $display("test selector table done");
        for (int k = 0; k < 3; k++) begin
            rs = next_rand(rs);
            @(posedge core_clk);
            ext_val <= rs[3:0]; ext_en <= 4'hF;
            settle(5);
            cmp_bit(esr, rs[0]);
            cmp_bit(trap, rs[1]);
            cmp_bit(brk, rs[1]);
            cmp_bit(pos0, rs[2]);
            cmp_bit(pos1, rs[3]);
            cmp_bit(s1in, rs[3]);
            cmp_bit(tdi, rs[2]);
            cmp_bit(tms, rs[3]);
            wb(1'b0, OFS_PORT_IN, 32'h0, 4'hF);
            cmp_word(q, {28'h0, rs[3:0]});
        end
        ext_en <= 4'h7;
        wb(1'b1, OFS_IOCR3, 32'hB0, 4'h1);
        settle(5);
        cmp_bit(pos1, per[5]);
        $display("test input routing done");
        wb(1'b1, OFS_IOCR0, 32'h90, 4'h1);
        tdo_oe <= 1'b1; tdo_out <= ~per[0];
        settle(2);
        cmp_bit(pin_oe[0], 1'b1);
        cmp_bit(pin_out[0], tdo_out);
        do_reset(1'b0, 2'h1, 1'b0);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        cmp_word(q, 32'h00000010);
        settle(1);
        cmp_bit(pin_oe[0], 1'b0);
        do_reset(1'b1, DBG_PORT_POS0, 1'b0);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        cmp_word(q, 32'h00000005);
        settle(1);
        cmp_bit(pin_oe[0], 1'b1);
        cmp_bit(pin_out[0], tdo_out);
        $display("test override and second start-up done");
        print_verdict();
    end
endmodule : tb_top
